// ===== rtl/fbpt_ctrl.sv
/*
  fbpt_ctrl.sv: flash controller enforcing per-block program and read
  enables and timing program and erase on the array.
  Assumes an array with combinational read of arr_addr_out, a non-volatile
  store that presents committed enables and accepts one-cycle commits, and
  a register master as described in the hand-over.
*/
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "fbpt_consts.svh"

module fbpt_ctrl #(
  parameter logic [15:0] ERASE_US = `FBPT_ERASE_US
) (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     nrst_in,
  // register port
  input  wire logic [7:0]               reg_addr_in,
  input  wire logic [31:0]              reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic [31:0]                   reg_rdata_out,
  // flash read requests (fetch or data, data covers debug)
  input  wire logic                     rd_req_in,
  input  wire logic [`FBPT_ADDR_W-1:0]  rd_addr_in,
  input  wire logic                     rd_fetch_in,
  output logic                          rd_ack_out,
  output logic                          rd_fault_out,
  output logic [31:0]                   rd_data_out,
  // flash array
  output logic [`FBPT_WORD_W-1:0]       arr_addr_out,
  output logic                          arr_wr_out,
  output logic [31:0]                   arr_wdata_out,
  output logic                          arr_erase_out,
  input  wire logic [31:0]              arr_rdata_in,
  // non-volatile enable store
  input  wire logic [31:0]              nv_prog_en_in,
  input  wire logic [31:0]              nv_read_en_in,
  output logic                          nv_commit_out,
  output logic                          nv_sel_prog_out,
  output logic [31:0]                   nv_data_out,
  // status
  output logic                          busy_out,
  output logic                          irq_out
);
  fbpt_pkg::fbpt_state_t state;
  logic [`FBPT_ADDR_W-1:0] target;
  logic [31:0]             wdata;
  logic [7:0]              usec_reload;
  logic [31:0]             block_program_enable;
  logic [31:0]             block_read_enable;
  logic [1:0]              raw_status;
  logic [1:0]              flash_irq_mask;
  logic                    loaded;
  logic                    rd_pend;
  logic [`FBPT_ADDR_W-1:0] rd_addr_q;
  logic                    rd_fetch_q;
  logic [15:0]             us_left;
  logic                    tick;
  logic                    wr_ctl;
  logic                    start_pg;
  logic                    start_er;
  logic                    start_cm;
  logic                    tgt_pe;
  logic                    rd_re;
  logic                    deny_op;
  logic                    op_done;
  logic [1:0]              set_status;
  logic [15:0]             hold_cycles;

  assign wr_ctl   = reg_wr_in && (reg_addr_in == `FBPT_OFF_CONTROL);
  assign start_pg = wr_ctl && reg_wdata_in[`FBPT_CTL_WRITE] && state == fbpt_pkg::FBPT_IDLE;
  assign start_er = wr_ctl && reg_wdata_in[`FBPT_CTL_ERASE] && state == fbpt_pkg::FBPT_IDLE
                    && !reg_wdata_in[`FBPT_CTL_WRITE];
  assign start_cm = wr_ctl && reg_wdata_in[`FBPT_CTL_COMMIT] && state == fbpt_pkg::FBPT_IDLE;
  // per-block enable lookups
  assign tgt_pe   = block_program_enable[target[`FBPT_PBLK_LSB +: `FBPT_PBLK_W]];
  assign rd_re    = block_read_enable[rd_addr_q[`FBPT_PBLK_LSB +: `FBPT_PBLK_W]];
  assign deny_op  = (start_pg || start_er) && !tgt_pe;
  assign op_done  = (state == fbpt_pkg::FBPT_PG_HOLD || state == fbpt_pkg::FBPT_ER_HOLD)
                    && tick && us_left == 16'h0001;
  assign set_status = {op_done, deny_op};

  fbpt_usec_timer fbpt_usec_timer_i (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .run_in    (state == fbpt_pkg::FBPT_PG_HOLD || state == fbpt_pkg::FBPT_ER_HOLD),
    .reload_in (usec_reload),
    .tick_out  (tick)
  );

  // plain configuration registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      target         <= '0;
      wdata          <= 32'h00000000;
      usec_reload    <= `FBPT_USEC_RESET;
      flash_irq_mask <= 2'h0;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        `FBPT_OFF_TARGET: target         <= reg_wdata_in[`FBPT_ADDR_W-1:0];
        `FBPT_OFF_WDATA:  wdata          <= reg_wdata_in;
        `FBPT_OFF_USEC:   usec_reload    <= reg_wdata_in[7:0];
        `FBPT_OFF_MASK:   flash_irq_mask <= reg_wdata_in[1:0];
        default: ;
      endcase
    end
  end

  // enables: all ones under reset, committed copy loaded on the first edge,
  // then software can only clear bits until the next power-on reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      block_program_enable <= `FBPT_PROT_RESET;
      block_read_enable    <= `FBPT_PROT_RESET;
      loaded               <= 1'b0;
    end else if (!loaded) begin
      block_program_enable <= nv_prog_en_in;
      block_read_enable    <= nv_read_en_in;
      loaded               <= 1'b1;
    end else if (reg_wr_in && reg_addr_in == `FBPT_OFF_PROG_EN) begin
      block_program_enable <= block_program_enable & reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == `FBPT_OFF_READ_EN) begin
      block_read_enable    <= block_read_enable & reg_wdata_in;
    end
  end

  // commit: one-cycle pulse to the store, register chosen by target bit 0
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      nv_commit_out   <= 1'b0;
      nv_sel_prog_out <= 1'b0;
      nv_data_out     <= 32'h00000000;
    end else begin
      nv_commit_out <= start_cm;
      if (start_cm) begin
        nv_sel_prog_out <= target[0];
        nv_data_out     <= target[0] ? block_program_enable : block_read_enable;
      end
    end
  end

  // sticky status, set beats a same-cycle clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      raw_status <= 2'h0;
    end else if (reg_wr_in && reg_addr_in == `FBPT_OFF_MSC) begin
      raw_status <= (raw_status & ~reg_wdata_in[1:0]) | set_status;
    end else begin
      raw_status <= raw_status | set_status;
    end
  end

  // interrupt is a flop so a masked-off event never glitches the line
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(raw_status & flash_irq_mask);
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `FBPT_OFF_TARGET:  reg_rdata_out <= {{(32-`FBPT_ADDR_W){1'b0}}, target};
        `FBPT_OFF_WDATA:   reg_rdata_out <= wdata;
        `FBPT_OFF_CONTROL: reg_rdata_out <= {30'h00000000,
                                             state == fbpt_pkg::FBPT_ER_HOLD,
                                             state == fbpt_pkg::FBPT_PG_READ ||
                                             state == fbpt_pkg::FBPT_PG_HOLD};
        `FBPT_OFF_RAW:     reg_rdata_out <= {30'h00000000, raw_status};
        `FBPT_OFF_MASK:    reg_rdata_out <= {30'h00000000, flash_irq_mask};
        `FBPT_OFF_MSC:     reg_rdata_out <= {30'h00000000, raw_status & flash_irq_mask};
        `FBPT_OFF_USEC:    reg_rdata_out <= {24'h000000, usec_reload};
        `FBPT_OFF_PROG_EN: reg_rdata_out <= block_program_enable;
        `FBPT_OFF_READ_EN: reg_rdata_out <= block_read_enable;
        default:           reg_rdata_out <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

  // one outstanding read; held off while the array is busy
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_pend    <= 1'b0;
      rd_addr_q  <= '0;
      rd_fetch_q <= 1'b0;
    end else if (rd_req_in && !rd_pend) begin
      rd_pend    <= 1'b1;
      rd_addr_q  <= rd_addr_in;
      rd_fetch_q <= rd_fetch_in;
    end else if (rd_pend && state == fbpt_pkg::FBPT_IDLE && !start_pg && !start_er) begin
      rd_pend    <= 1'b0;
    end
  end

  // cycles spent holding a program word; only the timing check reads it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_cycles <= 16'h0000;
    end else if (state == fbpt_pkg::FBPT_PG_HOLD) begin
      hold_cycles <= hold_cycles + 16'h0001;
    end else begin
      hold_cycles <= 16'h0000;
    end
  end

  // operation sequencer and array drive
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state         <= fbpt_pkg::FBPT_IDLE;
      us_left       <= 16'h0000;
      arr_addr_out  <= '0;
      arr_wr_out    <= 1'b0;
      arr_wdata_out <= 32'h00000000;
      arr_erase_out <= 1'b0;
      rd_ack_out    <= 1'b0;
      rd_fault_out  <= 1'b0;
      rd_data_out   <= 32'h00000000;
      busy_out      <= 1'b0;
    end else begin
      rd_ack_out   <= 1'b0;
      rd_fault_out <= 1'b0;
      unique case (state)
        fbpt_pkg::FBPT_IDLE: begin
          if ((start_pg || start_er) && !tgt_pe) begin
            busy_out <= 1'b0;
          end else if (start_pg) begin
            arr_addr_out <= target[`FBPT_ADDR_W-1:2];
            busy_out     <= 1'b1;
            state        <= fbpt_pkg::FBPT_PG_READ;
          end else if (start_er) begin
            arr_addr_out  <= {target[`FBPT_ADDR_W-1:`FBPT_EBLK_LSB], 8'h00};
            arr_erase_out <= 1'b1;
            us_left       <= ERASE_US;
            busy_out      <= 1'b1;
            state         <= fbpt_pkg::FBPT_ER_HOLD;
          end else if (rd_pend) begin
            if (!rd_fetch_q && !rd_re) begin
              rd_ack_out   <= 1'b1;
              rd_fault_out <= 1'b1;
              rd_data_out  <= 32'h00000000;
            end else begin
              arr_addr_out <= rd_addr_q[`FBPT_ADDR_W-1:2];
              state        <= fbpt_pkg::FBPT_RD_WAIT;
            end
          end
        end
        fbpt_pkg::FBPT_RD_WAIT: begin
          rd_ack_out  <= 1'b1;
          rd_data_out <= arr_rdata_in;
          state       <= fbpt_pkg::FBPT_IDLE;
        end
        fbpt_pkg::FBPT_PG_READ: begin
          arr_wdata_out <= arr_rdata_in & wdata;
          arr_wr_out    <= 1'b1;
          us_left       <= `FBPT_PROG_US;
          state         <= fbpt_pkg::FBPT_PG_HOLD;
        end
        fbpt_pkg::FBPT_PG_HOLD, fbpt_pkg::FBPT_ER_HOLD: begin
          if (tick) begin
            us_left <= us_left - 16'h0001;
          end
          if (op_done) begin
            arr_wr_out    <= 1'b0;
            arr_erase_out <= 1'b0;
            busy_out      <= 1'b0;
            state         <= fbpt_pkg::FBPT_IDLE;
          end
        end
      endcase
    end
  end

  a_deny_no_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    deny_op |=> !arr_wr_out && !arr_erase_out && raw_status[`FBPT_IRQ_ACCESS])
    else $error("refused operation touched the array");
  a_fault_on_re: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rd_fault_out |-> rd_ack_out && $past(!rd_fetch_q && !rd_re))
    else $error("fault without withdrawn read enable");
  a_fetch_no_fault: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state == fbpt_pkg::FBPT_IDLE && rd_pend && rd_fetch_q && !start_pg && !start_er
    |=> state == fbpt_pkg::FBPT_RD_WAIT ##1 rd_ack_out && !rd_fault_out)
    else $error("fetch not served");
  a_prog_clears: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(arr_wr_out) |-> (arr_wdata_out & ~$past(arr_rdata_in)) == 32'h00000000)
    else $error("program would set a bit");
  a_enable_clears: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $past(loaded) |-> (block_program_enable & ~$past(block_program_enable)) == 32'h0)
    else $error("program enable bit was set by software");
  a_irq_masked: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ##1 irq_out == $past(|(raw_status & flash_irq_mask)))
    else $error("interrupt disagrees with masked status");
  a_clear_status: assert property (@(posedge clk_in) disable iff (!nrst_in)
    reg_wr_in && reg_addr_in == `FBPT_OFF_MSC && reg_wdata_in[0] && !deny_op
    |=> !raw_status[`FBPT_IRQ_ACCESS])
    else $error("status not cleared");
  a_commit_sel: assert property (@(posedge clk_in) disable iff (!nrst_in)
    start_cm |=> nv_commit_out && nv_sel_prog_out == $past(target[0]))
    else $error("commit register selection wrong");
  // word held for the programmed microseconds of reload+1 cycles each
  a_prog_time: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state == fbpt_pkg::FBPT_PG_HOLD && op_done
    |-> busy_out && arr_wr_out
        && hold_cycles == `FBPT_PROG_US * ({8'h00, usec_reload} + 16'h0001))
    else $error("program hold time wrong");
  c_denied: cover property (@(posedge clk_in) deny_op);
  c_fault: cover property (@(posedge clk_in) rd_fault_out);
  c_erase: cover property (@(posedge clk_in) $fell(arr_erase_out));
  c_commit: cover property (@(posedge clk_in) nv_commit_out);
endmodule // fbpt_ctrl

// ===== rtl/fbpt_consts.svh
/*
  fbpt_consts.svh: offsets, field positions, reset values and timing figures
  for the flash block protection and timing controller.
  Assumes it is included by bare name from the design files.
*/
`ifndef FBPT_CONSTS_SVH
`define FBPT_CONSTS_SVH

// register word offsets on the plain register port
`define FBPT_OFF_TARGET    8'h00
`define FBPT_OFF_WDATA     8'h04
`define FBPT_OFF_CONTROL   8'h08
`define FBPT_OFF_RAW       8'h0C
`define FBPT_OFF_MASK      8'h10
`define FBPT_OFF_MSC       8'h14
`define FBPT_OFF_USEC      8'h18
`define FBPT_OFF_PROG_EN   8'h1C
`define FBPT_OFF_READ_EN   8'h20

// control register fields
`define FBPT_CTL_WRITE     0
`define FBPT_CTL_ERASE     1
`define FBPT_CTL_COMMIT    3

// status and mask fields
`define FBPT_IRQ_ACCESS    0
`define FBPT_IRQ_DONE      1

// geometry: byte address, 2-KB protection blocks, 1-KB erase blocks
`define FBPT_ADDR_W        15
`define FBPT_PBLK_LSB      11
`define FBPT_PBLK_W        4
`define FBPT_EBLK_LSB      10
`define FBPT_WORD_W        13

// reset values
`define FBPT_PROT_RESET    32'hFFFFFFFF
`define FBPT_MAX_MHZ       8'h32
`define FBPT_USEC_RESET    8'h31

// operation times in microseconds
`define FBPT_PROG_US       16'h0014
`define FBPT_ERASE_US      16'h07D0

`endif

// ===== rtl/fbpt_pkg.sv
/*
  fbpt_pkg.sv: types shared by the flash protection controller.
  Assumes nothing of its surroundings.
*/
package fbpt_pkg;
  typedef enum logic [2:0] {
    FBPT_IDLE,
    FBPT_RD_WAIT,
    FBPT_PG_READ,
    FBPT_PG_HOLD,
    FBPT_ER_HOLD
  } fbpt_state_t;
endpackage

// ===== rtl/fbpt_usec_timer.sv
/*
  fbpt_usec_timer.sv: microsecond tick from a cycles-per-microsecond reload.
  Assumes reload_in holds cycles per microsecond minus one.
*/
`timescale 1ns/1ps
`include "fbpt_consts.svh"

module fbpt_usec_timer (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // control
  input  wire logic       run_in,
  input  wire logic [7:0] reload_in,
  // tick
  output logic            tick_out
);
  logic [7:0] count;

  // count down, one tick per reload+1 cycles; restarts while idle
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      count    <= reload_in;
      tick_out <= 1'b0;
    end else if (count == 8'h00) begin
      count    <= reload_in;
      tick_out <= 1'b1;
    end else begin
      count    <= count - 8'h01;
      tick_out <= 1'b0;
    end
  end
endmodule // fbpt_usec_timer

// ===== verification/fbpt_flash_model.sv
/*
  fbpt_flash_model.sv: behavioural flash array and non-volatile enable store
  standing behind the protection controller.
  Assumes one clock shared with the controller; the store keeps its contents
  across controller resets, as a power-on reset would not erase it.
*/
`timescale 1ns/1ps
`include "fbpt_consts.svh"

module fbpt_flash_model (
  // clock
  input  wire logic                    clk_in,
  // array side
  input  wire logic [`FBPT_WORD_W-1:0] arr_addr_in,
  input  wire logic                    arr_wr_in,
  input  wire logic [31:0]             arr_wdata_in,
  input  wire logic                    arr_erase_in,
  output logic [31:0]                  arr_rdata_out,
  // enable store side
  input  wire logic                    nv_commit_in,
  input  wire logic                    nv_sel_prog_in,
  input  wire logic [31:0]             nv_data_in,
  output logic [31:0]                  nv_prog_en_out,
  output logic [31:0]                  nv_read_en_out
);
  logic [31:0] mem [0:8191];

  // known pattern, not all ones, so that an erase is visible
  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = 32'hA5000000 | i;
    nv_prog_en_out = 32'hFFFFFFFF;
    nv_read_en_out = 32'hFFFFFFFF;
  end

  assign arr_rdata_out = mem[arr_addr_in];

  // word written as given, so the controller must merge old and new itself
  always @(posedge clk_in) begin
    if (arr_wr_in) mem[arr_addr_in] <= arr_wdata_in;
    if (arr_erase_in) begin
      for (int i = 0; i < 256; i++) mem[{arr_addr_in[12:8], i[7:0]}] <= 32'hFFFFFFFF;
    end
    if (nv_commit_in && nv_sel_prog_in) nv_prog_en_out <= nv_prog_en_out & nv_data_in;
    if (nv_commit_in && !nv_sel_prog_in) nv_read_en_out <= nv_read_en_out & nv_data_in;
  end
endmodule // fbpt_flash_model

// ===== verification/flash_block_protection_timing_tb.sv
/*
  flash_block_protection_timing_tb.sv: self-checking bench for the flash
  protection and timing controller.
  Assumes the flash model file and the design files are compiled first.
*/
`timescale 1ns/1ps
`include "fbpt_consts.svh"

module flash_block_protection_timing_tb;
  logic                    clk_in, nrst_in, reg_wr_in, reg_rd_in, rd_req_in, rd_fetch_in;
  logic [7:0]              reg_addr_in;
  logic [31:0]             reg_wdata_in, reg_rdata_out, rd_data_out, arr_wdata, arr_rdata;
  logic [`FBPT_ADDR_W-1:0] rd_addr_in;
  logic [`FBPT_WORD_W-1:0] arr_addr;
  logic                    rd_ack_out, rd_fault_out, arr_wr, arr_erase, nv_commit, nv_sel;
  logic [31:0]             nv_prog_en, nv_read_en, nv_data, d;
  logic                    busy_out, irq_out, f;
  int                      n_errors = 0;
  int                      n_tests = 0;
  int                      n;

  // short erase so the run stays small
  fbpt_ctrl #(.ERASE_US(16'h0003)) fbpt_ctrl_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .rd_req_in(rd_req_in), .rd_addr_in(rd_addr_in),
    .rd_fetch_in(rd_fetch_in), .rd_ack_out(rd_ack_out), .rd_fault_out(rd_fault_out),
    .rd_data_out(rd_data_out), .arr_addr_out(arr_addr), .arr_wr_out(arr_wr),
    .arr_wdata_out(arr_wdata), .arr_erase_out(arr_erase), .arr_rdata_in(arr_rdata),
    .nv_prog_en_in(nv_prog_en), .nv_read_en_in(nv_read_en), .nv_commit_out(nv_commit),
    .nv_sel_prog_out(nv_sel), .nv_data_out(nv_data), .busy_out(busy_out), .irq_out(irq_out));

  fbpt_flash_model fbpt_flash_model_i (
    .clk_in(clk_in), .arr_addr_in(arr_addr), .arr_wr_in(arr_wr), .arr_wdata_in(arr_wdata),
    .arr_erase_in(arr_erase), .arr_rdata_out(arr_rdata), .nv_commit_in(nv_commit),
    .nv_sel_prog_in(nv_sel), .nv_data_in(nv_data), .nv_prog_en_out(nv_prog_en),
    .nv_read_en_out(nv_read_en));

  // 20 MHz system clock
  always #25 clk_in = ~clk_in;

  // power-on array pattern, indexed by byte address
  function automatic logic [31:0] pat(input logic [31:0] a);
    return 32'hA5000000 | (a >> 2);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // busy length may include the launch cycle
  task automatic chk_len(input int len, input int exp);
    chk({31'h0, len >= exp && len <= exp + 1}, 32'h1);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic timeout();
    chk(32'h0, 32'h1);
    summarize();
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    nrst_in <= 1'h0;
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'h1;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'h1;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'h1;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    #1 v = reg_rdata_out;
  endtask

  task automatic flash_rd(input logic [31:0] a, input logic fe, output logic fl,
                          output logic [31:0] v);
    @(posedge clk_in);
    rd_addr_in <= a[`FBPT_ADDR_W-1:0];
    rd_fetch_in <= fe;
    rd_req_in <= 1'h1;
    @(posedge clk_in);
    rd_req_in <= 1'h0;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk_in);
      #1;
      if (rd_ack_out === 1'h1) begin
        fl = rd_fault_out;
        v = rd_data_out;
        return;
      end
    end
    timeout();
  endtask

  // launch an operation and count its busy cycles; zero if it never starts
  task automatic run_op(input logic [31:0] ctl, output int len);
    int i;
    reg_wr(`FBPT_OFF_CONTROL, ctl);
    len = 0;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk_in);
      #1;
      if (busy_out === 1'h1) len++;
      else if (len > 0 || i > 4) break;
    end
    if (i == 3000) timeout();
  endtask

  task automatic prog(input logic [31:0] a, input logic [31:0] v, output int len);
    reg_wr(`FBPT_OFF_TARGET, a);
    reg_wr(`FBPT_OFF_WDATA, v);
    run_op(32'h00000001, len);
  endtask

  task automatic t_reset();
    reg_rd(`FBPT_OFF_USEC, d);
    chk(d, 32'h00000031);
    reg_rd(`FBPT_OFF_PROG_EN, d);
    chk(d, 32'hFFFFFFFF);
    reg_rd(`FBPT_OFF_READ_EN, d);
    chk(d, 32'hFFFFFFFF);
  endtask

  // 20 MHz gives 20 cycles a microsecond: program 400, erase 60
  task automatic t_program();
    reg_wr(`FBPT_OFF_USEC, 32'h00000013);
    prog(32'h00000010, 32'h0F0F00FF, n);
    chk_len(n, 400);
    prog(32'h00000010, 32'hFFFFFFF0, n);
    flash_rd(32'h00000010, 1'h0, f, d);
    chk(d, 32'h05000000);
    chk({31'h0, irq_out}, 32'h0);
    reg_wr(`FBPT_OFF_MASK, 32'h00000002);
    reg_rd(`FBPT_OFF_MSC, d);
    chk(d, 32'h00000002);
    chk({31'h0, irq_out}, 32'h1);
    reg_wr(`FBPT_OFF_MSC, 32'h00000002);
    reg_rd(`FBPT_OFF_RAW, d);
    chk(d, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
  endtask

  task automatic t_erase();
    reg_wr(`FBPT_OFF_TARGET, 32'h00000400);
    run_op(32'h00000002, n);
    chk_len(n, 60);
    flash_rd(32'h00000400, 1'h1, f, d);
    chk(d, 32'hFFFFFFFF);
    flash_rd(32'h000007FC, 1'h1, f, d);
    chk(d, 32'hFFFFFFFF);
    flash_rd(32'h000003FC, 1'h1, f, d);
    chk(d, pat(32'h000003FC));
    flash_rd(32'h00000800, 1'h1, f, d);
    chk(d, pat(32'h00000800));
  endtask

  // blocks 0..3 take the four policies: open, read-only, no-read, execute-only
  task automatic t_policy();
    logic [31:0] a;
    reg_wr(`FBPT_OFF_PROG_EN, 32'hFFFFFFF5);
    reg_wr(`FBPT_OFF_PROG_EN, 32'hFFFFFFFF);
    reg_rd(`FBPT_OFF_PROG_EN, d);
    chk(d, 32'hFFFFFFF5);
    reg_wr(`FBPT_OFF_READ_EN, 32'hFFFFFFF3);
    reg_wr(`FBPT_OFF_MASK, 32'h00000001);
    for (int b = 0; b < 4; b++) begin
      a = 32'h00000020 + b * 32'h00000800;
      flash_rd(a, 1'h0, f, d);
      chk({31'h0, f}, {31'h0, b[1]});
      chk(d, b[1] ? 32'h0 : pat(a));
      flash_rd(a, 1'h1, f, d);
      chk({31'h0, f}, 32'h0);
      chk(d, pat(a));
      prog(a, 32'h00000000, n);
      chk_len(n, b[0] ? 0 : 400);
      reg_rd(`FBPT_OFF_RAW, d);
      chk(d & 32'h1, {31'h0, b[0]});
      chk({31'h0, irq_out}, {31'h0, b[0]});
      flash_rd(a, 1'h1, f, d);
      chk(d, b[0] ? pat(a) : 32'h0);
      reg_wr(`FBPT_OFF_MSC, 32'h00000003);
    end
    reg_wr(`FBPT_OFF_MASK, 32'h00000000);
    reg_wr(`FBPT_OFF_TARGET, 32'h00001800);
    run_op(32'h00000002, n);
    chk_len(n, 0);
    reg_rd(`FBPT_OFF_RAW, d);
    chk(d, 32'h00000001);
    chk({31'h0, irq_out}, 32'h0);
    reg_wr(`FBPT_OFF_MSC, 32'h00000001);
  endtask

  // commit both registers, clear one more bit uncommitted, then power-cycle
  task automatic t_commit();
    reg_wr(`FBPT_OFF_TARGET, 32'h00000000);
    reg_wr(`FBPT_OFF_CONTROL, 32'h00000008);
    reg_wr(`FBPT_OFF_TARGET, 32'h00000001);
    reg_wr(`FBPT_OFF_CONTROL, 32'h00000008);
    reg_wr(`FBPT_OFF_PROG_EN, 32'hFFFFFFEF);
    repeat (3) @(posedge clk_in);
    do_reset();
    reg_rd(`FBPT_OFF_PROG_EN, d);
    chk(d, 32'hFFFFFFF5);
    reg_rd(`FBPT_OFF_READ_EN, d);
    chk(d, 32'hFFFFFFF3);
    flash_rd(32'h00001020, 1'h0, f, d);
    chk({31'h0, f}, 32'h1);
  endtask

  // main sequence
  initial begin
    clk_in = 1'h0;
    nrst_in = 1'h0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    reg_wr_in = 1'h0;
    reg_rd_in = 1'h0;
    rd_req_in = 1'h0;
    rd_addr_in = '0;
    rd_fetch_in = 1'h0;
    do_reset();
    t_reset();
    t_program();
    t_erase();
    t_policy();
    t_commit();
    summarize();
  end
endmodule // flash_block_protection_timing_tb
